/* hw/ldf_pkg.sv */
// Package: constants and carrier types for the load diagnostic and fault monitor
package ldf_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_HZ         = 50_000_000;
    localparam int unsigned DIAG_TIME_MS   = 229;
    localparam int unsigned DIAG_CYCLES    = (DIAG_TIME_MS * (CLK_HZ / 1000));
    localparam int unsigned CHECK_TRIES    = 5;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] REG_OUTPUT_PEAK_LIMIT = 8'h03;
    localparam logic [7:0] REG_DIAG_STATUS       = 8'h01;
    localparam logic [7:0] REG_FAULT_STATUS      = 8'h02;
    localparam logic [7:0] PEAK_LIMIT_RST        = 8'h00;

    // Fault status bit positions
    localparam int unsigned FB_OC  = 0;
    localparam int unsigned FB_DC  = 1;
    localparam int unsigned FB_OT  = 2;
    localparam int unsigned FB_UV  = 3;
    localparam int unsigned FB_OV  = 4;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        LOAD_NORMAL  = 3'h0,
        LOAD_SHORT_GND = 3'h1,
        LOAD_SHORT_PWR = 3'h2,
        LOAD_OPEN    = 3'h3,
        LOAD_SHORTED = 3'h4
    } ldf_load_t;

    typedef struct packed {
        logic overcurrent_shutdown;
        logic dc_offset;
        logic overtemperature_shutdown;
        logic supply_low_fault;
        logic supply_high_fault;
    } ldf_prot_t;

    typedef struct packed {
        logic      valid;
        logic      capacitive;
        ldf_load_t kind;
    } ldf_check_t;

    typedef enum logic [4:0] {
        ST_OFF  = 5'b00001,
        ST_DIAG = 5'b00010,
        ST_PLAY = 5'b00100,
        ST_HOLD = 5'b01000,
        ST_WAIT = 5'b10000
    } ldf_state_t;
endpackage : ldf_pkg

/* hw/ldf_monitor.sv */
// Load diagnostic sequencer, protection fault monitor and output limit
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// [R1] Diagnose on shutdown release and protection faults
// [R2] Bridge outputs high impedance during diagnostic
// [R3] Classify load: ground, supply, open, shorted, normal
// [R4] Full diagnostic pass lasts about 229 ms
// [R5] Check phase repeats up to five times
// [R6] Open load still lets audio play
// [R7] Other faults: stay off, recheck continuously
// [R8] Normal load enables output and playback
// [R9] Diagnose only on every second overvoltage
// [R10] Open load status only; others raise fault
// [R11] Temperature or supply faults abort diagnostic
// [R12] Overcurrent: high impedance, fault output, status
// [R13] DC offset monitored: fault output, status
// [R14] Overtemperature shuts down, resumes when cleared
// [R15] Undervoltage asserts fault, resets registers; the code restores only the peak limit, and fault status keeps its bits
// [R16] Power-on reset releases bus lines
// [R17] After power-on reset, registers at defaults
// [R18] Overvoltage asserts fault and records status
// [R19] One register value clamps both output polarities
// [R20] Fault output active low open drain
// [R21] System drives shutdown request low to stop
// [R22] Fault held while non-open faults remain
module ldf_monitor (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    input  wire logic              clk_en,
    // Pin and analog indications
    input  wire logic              shutdown_req_n,
    input  wire logic              power_on_reset,
    input  wire ldf_pkg::ldf_prot_t prot_in,
    input  wire ldf_pkg::ldf_check_t check_in,
    // Register port
    input  wire logic              reg_wr,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    output logic      [7:0]        reg_rdata,
    // Serial bus pin release
    output logic                   bus_release,
    // Bridge and limiter
    output logic                   bridge_hiz,
    output logic                   audio_play,
    output logic                   check_start,
    output logic      [7:0]        limit_pos,
    output logic      [7:0]        limit_neg,
    // Fault pin
    output logic                   fault_n_o,
    output logic                   fault_n_oe
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [6:0] sync1_q;
    logic [6:0] sync2_q;
    logic [6:0] raw_in;
    assign raw_in = {shutdown_req_n, power_on_reset, prot_in};

    // Two stages; only stage two feeds logic
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= 7'h00;
            sync2_q <= 7'h00;
        end else if (clk_en) begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    wire logic run_req = sync2_q[6];
    wire logic por     = sync2_q[5];
    wire ldf_pkg::ldf_prot_t prot = ldf_pkg::ldf_prot_t'(sync2_q[4:0]);
    wire logic abort_src = prot.overtemperature_shutdown | prot.supply_low_fault
                         | prot.supply_high_fault;
    wire logic any_prot = abort_src | prot.overcurrent_shutdown | prot.dc_offset;

    // Flags in status bit order; the carrier struct packs them the other way round
    wire logic [4:0] prot_vec;
    assign prot_vec[ldf_pkg::FB_OC] = prot.overcurrent_shutdown;
    assign prot_vec[ldf_pkg::FB_DC] = prot.dc_offset;
    assign prot_vec[ldf_pkg::FB_OT] = prot.overtemperature_shutdown;
    assign prot_vec[ldf_pkg::FB_UV] = prot.supply_low_fault;
    assign prot_vec[ldf_pkg::FB_OV] = prot.supply_high_fault;

    // ****************************************
    // Event edges
    // ****************************************
    logic [4:0] prot_prev_q;
    logic       run_prev_q;
    wire logic [4:0] prot_rise = prot_vec & ~prot_prev_q;
    wire logic run_rise = run_req & ~run_prev_q;
    wire logic ov_rise  = prot_rise[ldf_pkg::FB_OV];

    // Overvoltage parity: only every second event diagnoses
    logic ov_odd_q;
    wire logic ov_diag = ov_rise & ov_odd_q; // R9
    wire logic diag_trig = run_rise | ov_diag
                         | (|(prot_rise & ~(5'h01 << ldf_pkg::FB_OV))); // R1

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            prot_prev_q <= 5'h00;
            run_prev_q  <= 1'b0;
            ov_odd_q    <= 1'b0;
        end else if (clk_en) begin
            prot_prev_q <= prot_vec;
            run_prev_q  <= run_req;
            if (ov_rise) begin
                ov_odd_q <= ~ov_odd_q; // R9
            end
        end
    end

    // ****************************************
    // Diagnostic sequencer
    // ****************************************
    ldf_pkg::ldf_state_t state_q;
    ldf_pkg::ldf_state_t state_d;
    logic [23:0]         timer_q;
    logic [2:0]          tries_q;
    ldf_pkg::ldf_load_t  load_q;

    wire logic timer_done = (timer_q == 24'(ldf_pkg::DIAG_CYCLES - 1)); // R4
    wire logic chk_bad = check_in.valid
                       & ((check_in.kind != ldf_pkg::LOAD_NORMAL
                           & check_in.kind != ldf_pkg::LOAD_OPEN)
                          | check_in.capacitive);
    wire logic last_try = (tries_q == 3'(ldf_pkg::CHECK_TRIES - 1));

    // Next state; abort and shutdown take priority over results
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ldf_pkg::ST_OFF: begin
                if (run_req) begin
                    state_d = ldf_pkg::ST_DIAG; // R1
                end
            end
            ldf_pkg::ST_DIAG: begin
                if (abort_src) begin
                    state_d = ldf_pkg::ST_WAIT; // R11
                end else if (check_in.valid && timer_done) begin
                    if (!chk_bad) begin
                        state_d = ldf_pkg::ST_PLAY; // R6 R8
                    end else if (last_try) begin
                        state_d = ldf_pkg::ST_HOLD; // R7
                    end
                end
            end
            ldf_pkg::ST_PLAY: begin
                if (diag_trig) begin
                    state_d = ldf_pkg::ST_DIAG; // R1
                end else if (prot.overtemperature_shutdown) begin
                    state_d = ldf_pkg::ST_WAIT; // R14
                end
            end
            ldf_pkg::ST_HOLD: begin
                state_d = ldf_pkg::ST_DIAG; // R7
            end
            ldf_pkg::ST_WAIT: begin
                if (!abort_src) begin
                    state_d = ldf_pkg::ST_DIAG; // R14
                end
            end
            default: state_d = ldf_pkg::ST_OFF;
        endcase
        if (!run_req) begin
            state_d = ldf_pkg::ST_OFF; // R21
        end
    end

    // State, pass timer, check retry count and load result
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q <= ldf_pkg::ST_OFF;
            timer_q <= 24'h000000;
            tries_q <= 3'h0;
            load_q  <= ldf_pkg::LOAD_NORMAL;
        end else if (clk_en) begin
            state_q <= state_d;
            if (state_q != ldf_pkg::ST_DIAG || state_d != ldf_pkg::ST_DIAG) begin
                timer_q <= 24'h000000;
            end else if (!timer_done) begin
                timer_q <= timer_q + 24'h000001;
            end else if (check_in.valid) begin
                timer_q <= 24'h000000; // Rerun check phase
            end
            if (state_q != ldf_pkg::ST_DIAG) begin
                tries_q <= 3'h0;
            end else if (check_in.valid && timer_done && chk_bad && !last_try) begin
                tries_q <= tries_q + 3'h1; // R5
            end
            if (state_q == ldf_pkg::ST_DIAG && check_in.valid && timer_done) begin
                load_q <= check_in.kind; // R3
            end
        end
    end

    // Tell the analog checker to bias the output at each pass start
    assign check_start = (state_q == ldf_pkg::ST_DIAG) && (timer_q == 24'h000000);

    // ****************************************
    // Status and control registers
    // ****************************************
    logic [7:0] peak_q;
    logic [4:0] fault_sts_q;
    wire logic  regs_clear = prot.supply_low_fault | por; // R15 R17
    wire logic  rd_fault = (reg_addr == ldf_pkg::REG_FAULT_STATUS);
    wire logic  rd_peak  = (reg_addr == ldf_pkg::REG_OUTPUT_PEAK_LIMIT);
    wire logic  rd_diag  = (reg_addr == ldf_pkg::REG_DIAG_STATUS);

    // Undervoltage and power-on reset restore the limit default, power-on reset alone clears fault status; events win over writes
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            peak_q      <= ldf_pkg::PEAK_LIMIT_RST;
            fault_sts_q <= 5'h00;
        end else if (clk_en) begin
            if (regs_clear) begin
                peak_q <= ldf_pkg::PEAK_LIMIT_RST; // R15
            end else if (reg_wr && rd_peak) begin
                peak_q <= reg_wdata;
            end
            if (por) begin
                fault_sts_q <= 5'h00; // R17
            end else begin
                fault_sts_q <= (reg_wr && rd_fault ? fault_sts_q & ~reg_wdata[4:0]
                                                   : fault_sts_q)
                             | prot_vec; // R12 R13 R14 R18
            end
        end
    end

    // Read select, unmapped addresses read zero
    wire logic [7:0] rdata_d = rd_peak  ? peak_q
                             : rd_diag  ? {5'h00, load_q} // R10
                             : rd_fault ? {3'h0, fault_sts_q}
                             : 8'h00;
    logic [7:0]      rdata_q;

    // Read byte from a flop; costs one cycle after the address settles
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
        end else if (clk_en) begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // Bus lines released during power-on reset
    assign bus_release = por; // R16

    // ****************************************
    // Outputs
    // ****************************************
    wire logic load_fault = (load_q != ldf_pkg::LOAD_NORMAL) && (load_q != ldf_pkg::LOAD_OPEN);
    logic hiz_q;
    logic play_q;
    logic fault_q;

    // Registered so the bridge never sees decode glitches
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hiz_q   <= 1'b1;
            play_q  <= 1'b0;
            fault_q <= 1'b0;
        end else if (clk_en) begin
            hiz_q   <= (state_d != ldf_pkg::ST_PLAY) | prot.overcurrent_shutdown; // R2 R12
            play_q  <= (state_d == ldf_pkg::ST_PLAY) & ~prot.overcurrent_shutdown; // R8
            fault_q <= any_prot | (load_fault & (state_d != ldf_pkg::ST_OFF)); // R10 R22
        end
    end

    assign bridge_hiz = hiz_q;
    assign audio_play = play_q;
    assign limit_pos  = peak_q; // R19
    assign limit_neg  = peak_q; // R19
    assign fault_n_o  = 1'b0;
    assign fault_n_oe = fault_q; // R20

    // ****************************************
    // Assertions
    // ****************************************
    hiz_in_diag_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R2
        (state_q == ldf_pkg::ST_DIAG) |-> bridge_hiz)
        else $error("bridge driven during diagnostic");

    abort_diag_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R11
        (clk_en && run_req && state_q == ldf_pkg::ST_DIAG && abort_src)
        |=> state_q == ldf_pkg::ST_WAIT)
        else $error("diagnostic not aborted");

    oc_fault_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R12
        (clk_en && prot.overcurrent_shutdown) |=> (bridge_hiz && fault_n_oe))
        else $error("overcurrent not handled");

    dc_fault_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R13
        (clk_en && prot.dc_offset && !por) |=> (fault_n_oe && fault_sts_q[ldf_pkg::FB_DC]))
        else $error("dc offset not reported");

    ov_fault_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R18
        (clk_en && prot.supply_high_fault && !por)
        |=> (fault_n_oe && fault_sts_q[ldf_pkg::FB_OV]))
        else $error("overvoltage not reported");

    uv_reset_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R15
        (clk_en && prot.supply_low_fault) |=> (peak_q == ldf_pkg::PEAK_LIMIT_RST))
        else $error("registers not reset on undervoltage");

    limit_sym_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R19
        limit_pos == limit_neg)
        else $error("limits differ");

    ov_parity_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R9
        (clk_en && run_req && state_q == ldf_pkg::ST_PLAY && !ov_odd_q
         && !prot.overtemperature_shutdown && prot_rise == (5'h01 << ldf_pkg::FB_OV))
        |=> state_q == ldf_pkg::ST_PLAY)
        else $error("odd overvoltage diagnosed");

    por_bus_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R16
        por |-> bus_release)
        else $error("bus not released in reset");

    tries_max_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R5
        tries_q < 3'(ldf_pkg::CHECK_TRIES))
        else $error("too many check tries");

    play_ok_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R6 R8
        (clk_en && run_req && state_q == ldf_pkg::ST_DIAG && !abort_src && timer_done
         && check_in.valid && !chk_bad && !prot.overcurrent_shutdown)
        |=> (state_q == ldf_pkg::ST_PLAY && !bridge_hiz))
        else $error("good load did not start playback");

    hold_retry_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R7
        (clk_en && run_req && state_q == ldf_pkg::ST_HOLD)
        |=> (state_q == ldf_pkg::ST_DIAG && bridge_hiz))
        else $error("faulty load not checked again");

    open_quiet_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R10
        (clk_en && load_q == ldf_pkg::LOAD_OPEN && !any_prot) |=> !fault_n_oe)
        else $error("open load drove fault pin");

    fault_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R22
        (clk_en && load_fault && state_d != ldf_pkg::ST_OFF) |=> fault_n_oe)
        else $error("load fault not held on fault pin");

    ot_resume_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R14
        (clk_en && run_req && state_q == ldf_pkg::ST_WAIT && !abort_src)
        |=> state_q == ldf_pkg::ST_DIAG)
        else $error("no restart after fault cleared");

    shutdown_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R21
        (clk_en && !run_req) |=> state_q == ldf_pkg::ST_OFF)
        else $error("shutdown request ignored");
endmodule : ldf_monitor

`default_nettype wire

/* sim/ldf_load_model.sv */
// Speaker load model that answers the analog load check
`timescale 1ns/10ps
`default_nettype none
module ldf_load_model (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               nrst,
    // Check request and load set-up
    input  wire logic               check_start,
    input  wire logic               slow,
    input  wire ldf_pkg::ldf_load_t load_kind,
    // Analog check result
    output var ldf_pkg::ldf_check_t check_in
);
    logic [7:0] age_q;
    logic       flip_q;
    logic       ready;

    // Settle timer; a large capacitance makes the result late
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            age_q  <= 8'h00;
            flip_q <= 1'b0;
        end else begin
            flip_q <= ~flip_q;
            if (check_start) begin
                age_q <= 8'h01;
            end else if (age_q != 8'h00 && age_q != 8'hFF) begin
                age_q <= age_q + 8'h01;
            end
        end
    end

    // Before the result settles the lines wander, so no stale value is seen
    assign ready               = (age_q > (slow ? 8'h80 : 8'h04));
    assign check_in.valid      = ready;
    assign check_in.capacitive = ready ? slow : flip_q;
    assign check_in.kind       = ready ? load_kind
                                       : ldf_pkg::ldf_load_t'({flip_q, ~flip_q, flip_q});
endmodule : ldf_load_model
`default_nettype wire

/* sim/test_load_diag_fault_monitor.sv */
// Self-checking bench for the load diagnostic and fault monitor
`timescale 1ns/10ps
`default_nettype none
module test_load_diag_fault_monitor;
    typedef struct {
        int         idx;
        logic [7:0] exp;
    } ldf_note_t;

    // ****************************************
    // Signals and instances
    // ****************************************
    logic                clk_sys        = 1'b0;
    logic                nrst           = 1'b0;
    logic                clk_en         = 1'b1;
    logic                shutdown_req_n = 1'b0;
    logic                power_on_reset = 1'b0;
    logic                reg_wr         = 1'b0;
    logic [7:0]          reg_addr       = 8'h00;
    logic [7:0]          reg_wdata      = 8'h00;
    logic                slow           = 1'b0;
    ldf_pkg::ldf_prot_t  prot_in        = '0;
    ldf_pkg::ldf_check_t check_in;
    logic [7:0]          reg_rdata, limit_pos, limit_neg, lim;
    logic                bus_release, bridge_hiz, audio_play, check_start;
    logic                fault_n_o, fault_n_oe, start_seen;
    int                  mismatches = 0;
    int                  n_tests    = 0;
    ldf_note_t           notes[$];
    event                chk_ev;
    string               nm[9] = '{"bridge_hiz", "audio_play", "fault_n_oe", "limit_pos",
                                   "limit_neg", "reg_rdata", "bus_release", "check_start",
                                   "fault_n_o"};

    // 50 MHz system clock
    always #10 clk_sys = ~clk_sys;

    ldf_monitor dut (.clk_sys, .nrst, .clk_en, .shutdown_req_n, .power_on_reset, .prot_in,
                     .check_in, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .bus_release,
                     .bridge_hiz, .audio_play, .check_start, .limit_pos, .limit_neg,
                     .fault_n_o, .fault_n_oe);
    ldf_load_model load (.clk_sys, .nrst, .check_start, .slow,
                         .load_kind(ldf_pkg::LOAD_NORMAL), .check_in);

    // ****************************************
    // Scoreboard and tasks
    // ****************************************
    function automatic logic [7:0] obs(input int idx);
        case (idx)
            0: obs = {7'h00, bridge_hiz};
            1: obs = {7'h00, audio_play};
            2: obs = {7'h00, fault_n_oe};
            3: obs = limit_pos;
            4: obs = limit_neg;
            5: obs = reg_rdata;
            6: obs = {7'h00, bus_release};
            7: obs = {7'h00, start_seen};
            default: obs = {7'h00, fault_n_o};
        endcase
    endfunction : obs

    // Oldest note against what the outputs show now
    always @(chk_ev) begin
        ldf_note_t n;
        logic [7:0] got;
        while (notes.size() > 0) begin
            n = notes.pop_front();
            got = obs(n.idx);
            n_tests++;
            if (got !== n.exp) begin
                mismatches++;
                $display("[ERR] %s expected %h seen %h", nm[n.idx], n.exp, got);
            end
        end
    end

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    // Sampled on the falling edge, where outputs have settled
    task automatic chk(input int idx, input logic [7:0] exp);
        @(negedge clk_sys);
        notes.push_back('{idx, exp});
        -> chk_ev;
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : step

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        // Read byte comes from a flop, one edge after the address
        @(posedge clk_sys);
        chk(5, exp);
    endtask : rd

    // The pulse lasts one cycle, so every falling edge is looked at
    task automatic wait_start();
        start_seen = 1'b0;
        for (int i = 0; i < 12 && !start_seen; i++) begin
            @(negedge clk_sys);
            start_seen = (check_start === 1'b1);
        end
        if (!start_seen) begin
            mismatches++;
            finish_test();
        end
        chk(7, 8'h01);
    endtask : wait_start

    // Main sequence; a full pass is millions of cycles, so results are not reached
    initial begin
        void'($urandom(32'h927960FE));
        lim = 8'($urandom_range(255, 1));
        slow = 1'($urandom_range(1, 0));
        step(4);
        nrst <= 1'b1;
        step(4);
        chk(0, 8'h01);
        chk(2, 8'h00);
        chk(8, 8'h00);
        rd(ldf_pkg::REG_OUTPUT_PEAK_LIMIT, 8'h00);
        wr(ldf_pkg::REG_OUTPUT_PEAK_LIMIT, lim);
        chk(3, lim);
        chk(4, lim);
        rd(ldf_pkg::REG_OUTPUT_PEAK_LIMIT, lim);
        rd(8'h7F, 8'h00);
        @(posedge clk_sys);
        shutdown_req_n <= 1'b1;
        wait_start();
        chk(0, 8'h01);
        chk(1, 8'h00);
        // Overcurrent, dc offset, overtemperature, undervoltage in turn
        for (int b = 0; b < 4; b++) begin
            @(posedge clk_sys);
            prot_in <= ldf_pkg::ldf_prot_t'(5'h10 >> b);
            step(5);
            chk(2, 8'h01);
            chk(0, 8'h01);
            rd(ldf_pkg::REG_FAULT_STATUS, 8'h01 << b);
            if (b == 3) begin
                wr(ldf_pkg::REG_OUTPUT_PEAK_LIMIT, lim);
                rd(ldf_pkg::REG_OUTPUT_PEAK_LIMIT, 8'h00);
            end
            @(posedge clk_sys);
            prot_in <= '0;
            if (b >= 2) begin
                wait_start();
            end
            step(4);
            chk(2, 8'h00);
            wr(ldf_pkg::REG_FAULT_STATUS, 8'h01 << b);
            rd(ldf_pkg::REG_FAULT_STATUS, 8'h00);
        end
        @(posedge clk_sys);
        prot_in <= ldf_pkg::ldf_prot_t'(5'h01);
        step(5);
        chk(2, 8'h01);
        rd(ldf_pkg::REG_FAULT_STATUS, 8'h10);
        @(posedge clk_sys);
        prot_in <= '0;
        step(5);
        wr(ldf_pkg::REG_OUTPUT_PEAK_LIMIT, lim);
        // A write while the enable is low must be lost
        @(posedge clk_sys);
        clk_en <= 1'b0;
        wr(ldf_pkg::REG_OUTPUT_PEAK_LIMIT, ~lim);
        @(posedge clk_sys);
        clk_en <= 1'b1;
        rd(ldf_pkg::REG_OUTPUT_PEAK_LIMIT, lim);
        @(posedge clk_sys);
        power_on_reset <= 1'b1;
        step(5);
        chk(6, 8'h01);
        @(posedge clk_sys);
        power_on_reset <= 1'b0;
        step(5);
        chk(6, 8'h00);
        rd(ldf_pkg::REG_OUTPUT_PEAK_LIMIT, 8'h00);
        rd(ldf_pkg::REG_FAULT_STATUS, 8'h00);
        step(2);
        finish_test();
    end
endmodule : test_load_diag_fault_monitor
`default_nettype wire
